// File: filter_processor.sv
`timescale 1ns/1ns
//
// Contract
// [RULE1] Eight cells, each 9x9 multiply added into a 26-bit accumulator.
// [RULE2] Coefficient exits after one clock, plus 1 to 3 decimation clocks. Code also offers 0 extra clocks (DECIM_NONE).
// [RULE3] Cells chain rightward; last cell reaches pins only when enabled.
// [RULE4] Coefficient load enable registered; load on second clock after low.
// [RULE5] Coefficient and decimation registers hold while load enable high.
// [RULE6] Coefficient registers clear on registered reset, same latency.
// [RULE7] Sample load enable registered; sample loads second clock after low.
// [RULE8] Sample register loads zeros whenever sample load enable is high.
// [RULE9] Two product pipe stages; sign-extended sum feeds acc and hold.
// [RULE10] Hold register loads every clock except after cell selection.
// [RULE11] Accumulator takes adder output every clock unless cleared.
// [RULE12] Erase and reset both low clear everything, second clock after.
// [RULE13] Erase alone clears only the addressed cell accumulator.
// [RULE14] Reset alone clears all but accumulators; both high change nothing.
// [RULE15] Output adder adds selected cell to buffer upper 18 bits.
// [RULE16] Registered shift-add control picks zero or buffer upper bits.
// [RULE17] Result shows cell only if shift-add low now and previous clock.
// [RULE18] Unchanged address keeps the result from first selected clock.
// [RULE19] Low enable drives bits 0-15, high enable drives bits 16-25.
// [RULE20] Host supplies 9-bit two's complement; unsigned uses top bit zero.
// [RULE21] Cell product is 18 bits before sign extension.
// [RULE22] Cell address registered one clock before any selection.
// [RULE23] Each result half floats while its enable is high.
// [RULE24] Coefficients advance one cell per clock per decimation stage.
// [RULE25] All registers update on the rising edge of one clock.
//
module filter_processor
  import fir_pkg::*;
(
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  input  wire logic [COEF_W-1:0]   COEF_IN,
  input  wire logic                COEF_LOAD_ENABLE_N,
  input  wire logic                DECIM_SELECT_0,
  input  wire logic                DECIM_SELECT_1,
  input  wire logic                COEF_OUT_ENABLE_N,
  output logic      [COEF_W-1:0]   COEF_OUT,
  output logic                     COEF_OUT_OE,
  input  wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  input  wire logic                SAMPLE_LOAD_ENABLE_N,
  input  wire logic [ADDR_W-1:0]   CELL_ADDR,
  input  wire logic                SHIFT_ADD_CTL,
  input  wire logic                FILTER_RESET_N,
  input  wire logic                ERASE_N,
  input  wire logic                RESULT_LO_ENABLE_N,
  input  wire logic                RESULT_HI_ENABLE_N,
  output logic      [ACC_W-1:0]    RESULT_BUS,
  output logic                     RESULT_LO_OE,
  output logic                     RESULT_HI_OE
);

  // ----------------------------------------------------------------
  // Registered control inputs
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]   ctrl_d;
  logic [CTRL_W-1:0]   ctrl_q;
  logic                coef_load_q;
  logic                sample_load_q;
  logic                reset_q;
  logic                erase_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [DECIM_W-1:0]  decim_q;
  logic                shift_add_q;

  // Active-high forms of the pins, latched one clock
  assign ctrl_d = {~COEF_LOAD_ENABLE_N, ~SAMPLE_LOAD_ENABLE_N,
                   ~FILTER_RESET_N, ~ERASE_N, CELL_ADDR,
                   DECIM_SELECT_1, DECIM_SELECT_0, SHIFT_ADD_CTL};

  ctrl_reg u_ctrl (                                      // [RULE22]
    .clk (CLK_SYS),
    .rst (RST),
    .d   (ctrl_d),
    .q   (ctrl_q)
  );

  assign {coef_load_q, sample_load_q, reset_q, erase_q,
          addr_q, decim_q, shift_add_q} = ctrl_q;

  // ----------------------------------------------------------------
  // Shared sample register
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] sample, next_sample;

  // Sample loads when enabled, zero otherwise
  always_comb begin
    next_sample = sample_load_q ? SAMPLE_IN : SAMPLE_RST; // [RULE7] [RULE8]
    if (reset_q) begin
      next_sample = SAMPLE_RST;                          // [RULE14]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sample <= SAMPLE_RST;
    end else begin
      sample <= next_sample;
    end
  end

  // ----------------------------------------------------------------
  // Cell array
  // ----------------------------------------------------------------
  logic [COEF_W-1:0] coef_chain [N_CELLS+1];
  logic [ACC_W-1:0]  hold_arr   [N_CELLS];
  logic [N_CELLS-1:0] cell_hit;
  logic [N_CELLS-1:0] acc_clr;

  assign coef_chain[0] = COEF_IN;

  genvar g;
  generate
    for (g = 0; g < N_CELLS; g++) begin : gen_cell
      // Decoded cell select and accumulator clear
      assign cell_hit[g] = (addr_q == ADDR_W'(g));      // [RULE22]
      assign acc_clr[g]  = erase_q & (reset_q | cell_hit[g]); // [RULE12] [RULE13]

      fir_cell u_cell (
        .clk       (CLK_SYS),
        .rst       (RST),
        .coef_load (coef_load_q),
        .decim_sel (decim_q),
        .regs_clr  (reset_q),
        .acc_clr   (acc_clr[g]),
        .cell_hit  (cell_hit[g]),
        .sample    (sample),
        .coef_in   (coef_chain[g]),
        .coef_out  (coef_chain[g+1]),                   // [RULE3]
        .hold      (hold_arr[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic [ACC_W-1:0]  out_buffer, next_out_buffer;
  logic [ACC_W-1:0]  result, next_result;
  logic [ACC_W-1:0]  sel_hold;
  logic [ACC_W-1:0]  feedback;
  logic              shift_add_prev, next_shift_add_prev;
  logic [ADDR_W-1:0] addr_prev, next_addr_prev;
  logic              cell_path;
  logic              cell_path_prev, next_cell_path_prev;

  assign sel_hold = hold_arr[addr_q];

  // Shift-and-add, result mux and address memory
  always_comb begin
    feedback = shift_add_q ? {{SHIFT_W{out_buffer[ACC_W-1]}},
                              out_buffer[ACC_W-1:SHIFT_W]}
                           : ACC_RST;                    // [RULE16]
    next_out_buffer     = sel_hold + feedback;           // [RULE15]
    cell_path           = !shift_add_q && !shift_add_prev; // [RULE17]
    next_shift_add_prev = shift_add_q;
    next_addr_prev      = addr_q;
    next_cell_path_prev = cell_path;
    if (!cell_path) begin
      next_result = out_buffer;                          // [RULE17]
    end else if (addr_q != addr_prev || !cell_path_prev) begin
      next_result = sel_hold;
    end else begin
      next_result = result;                              // [RULE18]
    end
    if (reset_q) begin
      next_out_buffer = ACC_RST;                         // [RULE14]
      next_result     = ACC_RST;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      out_buffer     <= ACC_RST;
      result         <= ACC_RST;
      shift_add_prev <= 1'b0;
      addr_prev      <= '0;
      cell_path_prev <= 1'b0;
    end else begin
      out_buffer     <= next_out_buffer;
      result         <= next_result;
      shift_add_prev <= next_shift_add_prev;
      addr_prev      <= next_addr_prev;
      cell_path_prev <= next_cell_path_prev;
    end
  end

  // ----------------------------------------------------------------
  // Pin registers and drive enables
  // ----------------------------------------------------------------
  logic [COEF_W-1:0] next_coef_out;
  logic              next_coef_out_oe;
  logic              next_lo_oe;
  logic              next_hi_oe;

  always_comb begin
    next_coef_out    = coef_chain[N_CELLS];              // [RULE3]
    next_coef_out_oe = ~COEF_OUT_ENABLE_N;               // [RULE3]
    next_lo_oe       = ~RESULT_LO_ENABLE_N;              // [RULE19] [RULE23]
    next_hi_oe       = ~RESULT_HI_ENABLE_N;              // [RULE19] [RULE23]
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      COEF_OUT     <= COEF_RST;
      COEF_OUT_OE  <= 1'b0;
      RESULT_LO_OE <= 1'b0;
      RESULT_HI_OE <= 1'b0;
    end else begin
      COEF_OUT     <= next_coef_out;
      COEF_OUT_OE  <= next_coef_out_oe;
      RESULT_LO_OE <= next_lo_oe;
      RESULT_HI_OE <= next_hi_oe;
    end
  end

  assign RESULT_BUS = result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  property p_sample_zero;
    (!sample_load_q && !reset_q) |=> sample == SAMPLE_RST;
  endproperty
  a_sample_zero: assert property (p_sample_zero) // [RULE8]
    else $error("sample register not zeroed");

  property p_sample_load;
    (!SAMPLE_LOAD_ENABLE_N && FILTER_RESET_N)
      |-> ##2 sample == $past(SAMPLE_IN);
  endproperty
  a_sample_load: assert property (p_sample_load) // [RULE7]
    else $error("sample not loaded on second clock");

  property p_coef_load;
    (!COEF_LOAD_ENABLE_N && FILTER_RESET_N)
      |-> ##2 gen_cell[0].u_cell.coef_reg == $past(COEF_IN);
  endproperty
  a_coef_load: assert property (p_coef_load) // [RULE4]
    else $error("coefficient not loaded on second clock");

  property p_coef_freeze;
    (!coef_load_q && !reset_q) |=> $stable(gen_cell[2].u_cell.coef_reg);
  endproperty
  a_coef_freeze: assert property (p_coef_freeze) // [RULE5]
    else $error("coefficient changed while frozen");

  property p_reset_clear;
    (!FILTER_RESET_N) |-> ##2 (gen_cell[7].u_cell.coef_reg == COEF_RST
                              && out_buffer == ACC_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [RULE6] [RULE14]
    else $error("registers not cleared by reset");

  property p_erase_all;
    (!FILTER_RESET_N && !ERASE_N) |-> ##2 gen_cell[4].u_cell.acc == ACC_RST;
  endproperty
  a_erase_all: assert property (p_erase_all) // [RULE12]
    else $error("accumulator survived reset with erase");

  property p_erase_one;
    (erase_q && !reset_q && addr_q == 3'h5)
      |=> gen_cell[5].u_cell.acc == ACC_RST;
  endproperty
  a_erase_one: assert property (p_erase_one) // [RULE13]
    else $error("selected accumulator not erased");

  property p_shift_add;
    shift_add_q && !reset_q |=> out_buffer == $past(sel_hold)
      + {{SHIFT_W{$past(out_buffer[ACC_W-1])}},
         $past(out_buffer[ACC_W-1:SHIFT_W])};
  endproperty
  a_shift_add: assert property (p_shift_add) // [RULE15] [RULE16]
    else $error("shift-and-add result wrong");

  property p_result_buffer;
    (shift_add_q && !reset_q) |=> RESULT_BUS == $past(out_buffer);
  endproperty
  a_result_buffer: assert property (p_result_buffer) // [RULE17]
    else $error("result bus not showing output buffer");

  property p_result_held;
    (cell_path && cell_path_prev && addr_q == addr_prev && !reset_q)
      |=> $stable(RESULT_BUS);
  endproperty
  a_result_held: assert property (p_result_held) // [RULE18]
    else $error("result changed for unchanged address");

  property p_lo_float;
    RESULT_LO_ENABLE_N |=> !RESULT_LO_OE;
  endproperty
  a_lo_float: assert property (p_lo_float) // [RULE23]
    else $error("low half driven while disabled");

  property p_hi_float;
    RESULT_HI_ENABLE_N |=> !RESULT_HI_OE;
  endproperty
  a_hi_float: assert property (p_hi_float) // [RULE23]
    else $error("high half driven while disabled");

  // Last cell exit reaches the pins one clock later
  property p_coef_pins;
    !COEF_OUT_ENABLE_N |=> (COEF_OUT_OE
                            && COEF_OUT == $past(coef_chain[N_CELLS]));
  endproperty
  a_coef_pins: assert property (p_coef_pins) // [RULE3]
    else $error("coefficient pins not fed from last cell");

  // First clock of cell path shows the selected hold register
  property p_result_cell;
    (cell_path && !cell_path_prev && !reset_q)
      |=> RESULT_BUS == $past(sel_hold);
  endproperty
  a_result_cell: assert property (p_result_cell) // [RULE17]
    else $error("result bus not showing selected cell");

  c_shift_add:  cover property (shift_add_q ##1 shift_add_q);
  c_erase_one:  cover property (erase_q && !reset_q);
  c_decim_full: cover property (decim_q == DECIM_THREE && coef_load_q);
  c_held:       cover property (cell_path && addr_q == addr_prev);

endmodule

// File: fir_pkg.sv
package fir_pkg;

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int N_CELLS   = 8;
  localparam int COEF_W    = 9;
  localparam int SAMPLE_W  = 9;
  localparam int PROD_W    = 18;
  localparam int ACC_W     = 26;
  localparam int ADDR_W    = 3;
  localparam int DECIM_W   = 2;
  localparam int SHIFT_W   = 8;
  localparam int UPPER_W   = ACC_W - SHIFT_W;
  localparam int LO_HALF_W = 16;
  localparam int CTRL_W    = 4 + ADDR_W + DECIM_W + 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [COEF_W-1:0]   COEF_RST   = 9'h000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 9'h000;
  localparam logic [PROD_W-1:0]   PROD_RST   = 18'h00000;
  localparam logic [ACC_W-1:0]    ACC_RST    = 26'h0000000;
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 10'h000;

  // ----------------------------------------------------------------
  // Decimation depth selections
  // ----------------------------------------------------------------
  localparam logic [DECIM_W-1:0] DECIM_NONE = 2'h0;
  localparam logic [DECIM_W-1:0] DECIM_ONE  = 2'h1;
  localparam logic [DECIM_W-1:0] DECIM_TWO  = 2'h2;
  localparam logic [DECIM_W-1:0] DECIM_THREE = 2'h3;

endpackage

// File: ctrl_reg.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Input latch for control pins, one clock of delay
// ------------------------------------------------------------------
module ctrl_reg
  import fir_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [CTRL_W-1:0] d,
  output logic      [CTRL_W-1:0] q
);

  logic [CTRL_W-1:0] next_q;

  // Next value is simply the pin state
  always_comb begin
    next_q = d;
  end

  // Register, inactive state after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= CTRL_RST;
    end else begin
      q <= next_q;
    end
  end

endmodule

// File: fir_cell.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// One multiply-accumulate cell
// ------------------------------------------------------------------
module fir_cell
  import fir_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                coef_load,
  input  wire logic [DECIM_W-1:0]  decim_sel,
  input  wire logic                regs_clr,
  input  wire logic                acc_clr,
  input  wire logic                cell_hit,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic [COEF_W-1:0]   coef_in,
  output logic      [COEF_W-1:0]   coef_out,
  output logic      [ACC_W-1:0]    hold
);

  logic        [COEF_W-1:0] coef_reg, next_coef_reg;
  logic        [COEF_W-1:0] decim_stage_1, next_decim_stage_1;
  logic        [COEF_W-1:0] decim_stage_2, next_decim_stage_2;
  logic        [COEF_W-1:0] decim_stage_3, next_decim_stage_3;
  logic signed [PROD_W-1:0] product_pipe_0, next_product_pipe_0;
  logic signed [PROD_W-1:0] product_pipe_1, next_product_pipe_1;
  logic        [ACC_W-1:0]  acc, next_acc;
  logic        [ACC_W-1:0]  cell_hold_reg, next_cell_hold_reg;
  logic        [ACC_W-1:0]  sum;

  // ----------------------------------------------------------------
  // Next state of the cell
  // ----------------------------------------------------------------
  always_comb begin
    sum = acc + {{(ACC_W-PROD_W){product_pipe_1[PROD_W-1]}},
                 product_pipe_1};                        // [RULE9] [RULE21]
    next_coef_reg       = coef_reg;
    next_decim_stage_1  = decim_stage_1;
    next_decim_stage_2  = decim_stage_2;
    next_decim_stage_3  = decim_stage_3;
    next_product_pipe_0 = $signed(coef_reg) * $signed(sample); // [RULE1]
    next_product_pipe_1 = product_pipe_0;                // [RULE9]
    next_cell_hold_reg  = cell_hit ? cell_hold_reg : sum; // [RULE10]
    if (coef_load) begin
      next_coef_reg      = coef_in;                      // [RULE4]
      next_decim_stage_1 = coef_reg;                     // [RULE2]
      next_decim_stage_2 = decim_stage_1;
      next_decim_stage_3 = decim_stage_2;
    end                                                  // [RULE5]
    if (regs_clr) begin
      next_coef_reg       = COEF_RST;                    // [RULE6] [RULE14]
      next_decim_stage_1  = COEF_RST;
      next_decim_stage_2  = COEF_RST;
      next_decim_stage_3  = COEF_RST;
      next_product_pipe_0 = PROD_RST;
      next_product_pipe_1 = PROD_RST;
      next_cell_hold_reg  = ACC_RST;
    end
    next_acc = acc_clr ? ACC_RST : sum;                  // [RULE11]
  end

  // Coefficient exit point chosen by decimation depth
  always_comb begin
    case (decim_sel)                                     // [RULE2] [RULE24]
      DECIM_NONE:  coef_out = coef_reg;
      DECIM_ONE:   coef_out = decim_stage_1;
      DECIM_TWO:   coef_out = decim_stage_2;
      DECIM_THREE: coef_out = decim_stage_3;
      default:     coef_out = coef_reg;
    endcase
  end

  assign hold = cell_hold_reg;

  // Cell registers
  always_ff @(posedge clk) begin                         // [RULE25]
    if (rst) begin
      coef_reg       <= COEF_RST;
      decim_stage_1  <= COEF_RST;
      decim_stage_2  <= COEF_RST;
      decim_stage_3  <= COEF_RST;
      product_pipe_0 <= PROD_RST;
      product_pipe_1 <= PROD_RST;
      acc            <= ACC_RST;
      cell_hold_reg  <= ACC_RST;
    end else begin
      coef_reg       <= next_coef_reg;
      decim_stage_1  <= next_decim_stage_1;
      decim_stage_2  <= next_decim_stage_2;
      decim_stage_3  <= next_decim_stage_3;
      product_pipe_0 <= next_product_pipe_0;
      product_pipe_1 <= next_product_pipe_1;
      acc            <= next_acc;
      cell_hold_reg  <= next_cell_hold_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold_frozen;
    @(posedge clk) disable iff (rst)
    (cell_hit && !regs_clr) |=> $stable(cell_hold_reg);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) // [RULE10]
    else $error("hold register changed while cell selected");

  property p_acc_accum;
    @(posedge clk) disable iff (rst)
    !acc_clr |=> acc == $past(sum);
  endproperty
  a_acc_accum: assert property (p_acc_accum) // [RULE11]
    else $error("accumulator did not take adder output");

endmodule

// File: host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host side: operand feed and result bus view
// ----------------------------------------------------------------
module host_model
  import fir_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [ACC_W-1:0]    bus,
  input  wire logic                lo_oe,
  input  wire logic                hi_oe,
  output logic      [COEF_W-1:0]   coef_in,
  output logic                     coef_en_n,
  output logic      [SAMPLE_W-1:0] sample_in,
  output logic                     sample_en_n,
  output logic                     lo_en_n,
  output logic                     hi_en_n,
  output logic      [ACC_W-1:0]    wire_val
);
  logic [ACC_W-1:0] last = '0;

  // Released halves show the inverse of the last level, no pull
  always @(posedge clk) last <= wire_val;
  assign wire_val[15:0]  = lo_oe ? bus[15:0]  : ~last[15:0];
  assign wire_val[25:16] = hi_oe ? bus[25:16] : ~last[25:16];

  // Idle pins at time zero
  initial begin
    coef_in     = '0;
    coef_en_n   = 1'b1;
    sample_in   = '0;
    sample_en_n = 1'b1;
    lo_en_n     = 1'b0;
    hi_en_n     = 1'b0;
  end

  // Enable low one cycle before the coefficient; pre is a decoy
  task automatic coef_load(input logic [COEF_W-1:0] pre, c,
                           input int n);
    @(negedge clk);
    coef_en_n = 1'b0;
    coef_in   = pre;
    @(negedge clk);
    coef_in = c;
    repeat (n) @(negedge clk);
  endtask

  // Exactly k samples of x, enable leading the data by one cycle
  task automatic feed(input logic [SAMPLE_W-1:0] x, input int k);
    @(negedge clk);
    sample_en_n = 1'b0;
    sample_in   = '0;
    repeat (k) begin
      @(negedge clk);
      sample_in = x;
    end
    sample_en_n = 1'b1;
    @(negedge clk);
    sample_in = '0;
  endtask

  // Narrow host: low group first, then the high group, bits 16-25
  task automatic read_pair(output logic [ACC_W-1:0] v);
    @(negedge clk);
    hi_en_n = 1'b1;
    repeat (3) @(negedge clk);
    v[15:0] = wire_val[15:0];
    hi_en_n = 1'b0;
    lo_en_n = 1'b1;
    repeat (3) @(negedge clk);
    v[25:16] = wire_val[25:16];
    lo_en_n = 1'b0;
  endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
`define CHECK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module testbench
  import fir_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic decim0 = 1'b0, decim1 = 1'b0, coef_oe_n = 1'b0, shift_add = 1'b0;
  logic frst_n = 1'b1, erase_n = 1'b1;
  logic [ADDR_W-1:0] cell_addr = '0;
  logic [COEF_W-1:0] coef_in, coef_out;
  logic [SAMPLE_W-1:0] sample_in;
  logic coef_en_n, sample_en_n, lo_en_n, hi_en_n;
  logic coef_oe, lo_oe, hi_oe;
  logic [ACC_W-1:0] result_bus, wire_val, v;
  int num_errors = 0, compares = 0, cycles = 0, decoy_hits = 0;

  filter_processor filter_processor_inst (
    .CLK_SYS(clk), .RST(rst), .COEF_IN(coef_in),
    .COEF_LOAD_ENABLE_N(coef_en_n), .DECIM_SELECT_0(decim0),
    .DECIM_SELECT_1(decim1), .COEF_OUT_ENABLE_N(coef_oe_n),
    .COEF_OUT(coef_out), .COEF_OUT_OE(coef_oe), .SAMPLE_IN(sample_in),
    .SAMPLE_LOAD_ENABLE_N(sample_en_n), .CELL_ADDR(cell_addr),
    .SHIFT_ADD_CTL(shift_add), .FILTER_RESET_N(frst_n), .ERASE_N(erase_n),
    .RESULT_LO_ENABLE_N(lo_en_n), .RESULT_HI_ENABLE_N(hi_en_n),
    .RESULT_BUS(result_bus), .RESULT_LO_OE(lo_oe), .RESULT_HI_OE(hi_oe));

  host_model host_model_inst (
    .clk(clk), .bus(result_bus), .lo_oe(lo_oe), .hi_oe(hi_oe),
    .coef_in(coef_in), .coef_en_n(coef_en_n), .sample_in(sample_in),
    .sample_en_n(sample_en_n), .lo_en_n(lo_en_n), .hi_en_n(hi_en_n),
    .wire_val(wire_val));

  // Clock, hang guard and decoy watch
  always #4 clk = ~clk;
  always @(negedge clk) if (coef_out === 9'h0b3) decoy_hits++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic read_cell(input logic [ADDR_W-1:0] a,
                           input logic [ACC_W-1:0] ex);
    @(negedge clk);
    cell_addr = a;
    repeat (4) @(negedge clk);
    `CHECK("cell sum", ex, wire_val)
  endtask

  // Clear all, load -3 everywhere, then freeze the flow
  task automatic t_coef();
    frst_n  = 1'b0;
    erase_n = 1'b0;
    repeat (3) @(negedge clk);
    frst_n  = 1'b1;
    erase_n = 1'b1;
    host_model_inst.coef_load(9'h0b3, 9'h1fd, 20);
    `CHECK("coef out", 9'h1fd, coef_out)
    `CHECK("coef oe", 1'b1, coef_oe)
    host_model_inst.coef_en_n = 1'b1;
    @(negedge clk);
    host_model_inst.coef_in = 9'h055;
    repeat (20) @(negedge clk);
    `CHECK("frozen coef", 9'h1fd, coef_out)
    `CHECK("decoy seen", 0, decoy_hits)
    coef_oe_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("coef oe off", 1'b0, coef_oe)
    coef_oe_n = 1'b0;
  endtask

  // Five products into every cell, then a held address and more sums
  task automatic t_mac();
    cell_addr = 3'h7;
    host_model_inst.feed(9'h064, 5);
    repeat (12) @(negedge clk);
    for (int i = 0; i < N_CELLS; i++)
      read_cell(i[2:0], ACC_W'(-3 * 100 * 5));
    host_model_inst.feed(9'h19c, 10);
    repeat (12) @(negedge clk);
    `CHECK("held addr", ACC_W'(-1500), wire_val)
    read_cell(3'h5, ACC_W'(1500));
    read_cell(3'h7, ACC_W'(1500));
  endtask

  // Steady shift-add: b = 1500 + b/256 settles at 1505
  task automatic t_shift();
    shift_add = 1'b1;
    repeat (10) @(negedge clk);
    `CHECK("shift add", ACC_W'(1505), wire_val)
    shift_add = 1'b0;
    repeat (4) @(negedge clk);
    `CHECK("cell path", ACC_W'(1500), wire_val)
  endtask

  task automatic t_halves();
    host_model_inst.hi_en_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("lo oe", 1'b1, lo_oe)
    `CHECK("hi oe", 1'b0, hi_oe)
    host_model_inst.hi_en_n = 1'b0;
    host_model_inst.read_pair(v);
    `CHECK("paired read", ACC_W'(1500), v)
  endtask

  // Single erase, then reset alone, then both together
  task automatic t_clear();
    cell_addr = 3'h5;
    repeat (2) @(negedge clk);
    erase_n = 1'b0;
    @(negedge clk);
    erase_n = 1'b1;
    read_cell(3'h3, ACC_W'(1500));
    read_cell(3'h5, '0);
    frst_n = 1'b0;
    repeat (3) @(negedge clk);
    frst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHECK("coef cleared", 9'h000, coef_out)
    read_cell(3'h4, ACC_W'(1500));
    frst_n  = 1'b0;
    erase_n = 1'b0;
    repeat (3) @(negedge clk);
    frst_n  = 1'b1;
    erase_n = 1'b1;
    read_cell(3'h6, '0);
  endtask

  // Each decimation stage adds one clock per cell to the chain
  task automatic t_decim();
    int lat[4];
    int n;
    for (int d = 0; d < 4; d++) begin
      {decim1, decim0} = d[1:0];
      host_model_inst.coef_load(9'h0aa, 9'h0aa, 60);
      host_model_inst.coef_in = 9'h055;
      n = 0;
      while (coef_out !== 9'h055 && n < 100) begin
        @(negedge clk);
        n++;
      end
      lat[d] = n;
      `CHECK("decim delay", N_CELLS * d, lat[d] - lat[0])
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_coef();
    t_mac();
    t_shift();
    t_halves();
    t_clear();
    t_decim();
    report_and_stop();
  end
endmodule
